// ==== rtl/pac_pkg.sv ====
package pac_pkg;

  // ---------------------------------------------------------------
  // Widths and bit positions
  // ---------------------------------------------------------------
  localparam int ADC_W = 10;
  localparam int LEVEL_W = 12;
  localparam int PROD_W = LEVEL_W + ADC_W;
  localparam int RESULT_BIT_LSB = 0;
  localparam int RESULT_BIT_MSB = ADC_W - 1;
  localparam logic [ADC_W-1:0] CODE_ALL_ONES = 10'h3ff;
  localparam logic [ADC_W-1:0] CODE_ALL_ZEROS = 10'h000;
  localparam logic [ADC_W-1:0] TRIAL_FIRST = 10'h200;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_NS = 4;
  // Internal step period; one step resolves one bit
  localparam int INT_STEP_NS = 500;
  localparam int INT_STEP_CYC = (INT_STEP_NS + CLK_NS - 1) / CLK_NS;
  // Delay before the internal clock gives way to the external one
  localparam int EXT_SWITCH_NS = 4000;
  localparam int EXT_SWITCH_CYC = (EXT_SWITCH_NS + CLK_NS - 1) / CLK_NS;
  // No external edge for this long means the input is stalled low or tied high
  localparam int EXT_IDLE_NS = 4000;
  localparam int EXT_IDLE_CYC = (EXT_IDLE_NS + CLK_NS - 1) / CLK_NS;
  // Longest time from read fall to done flag high
  localparam int DONE_CLR_NS = 20;
  localparam int DONE_CLR_CYC = (DONE_CLR_NS / CLK_NS < 1) ? 1 :
                                DONE_CLR_NS / CLK_NS;
  localparam int CNT_W = 11;
  localparam logic [7:0] INT_STEP_LAST = 8'(INT_STEP_CYC - 1);
  localparam logic [CNT_W-1:0] EXT_SWITCH_LAST = CNT_W'(EXT_SWITCH_CYC - 1);
  localparam logic [CNT_W-1:0] EXT_IDLE_LAST = CNT_W'(EXT_IDLE_CYC - 1);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {st_track, st_convert, st_transfer} pac_state_e;

  typedef struct packed {
    logic cs_n;
    logic wr_n;
    logic rd_n;
  } pac_strobe_s;

  typedef struct packed {
    logic [ADC_W-1:0] data;
    logic oe;
  } pac_bus_s;

endpackage

// ==== rtl/pac_sar_core.sv ====
`timescale 1ns/1ps
module pac_sar_core (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic step,
  input wire logic [pac_pkg::LEVEL_W-1:0] held,
  input wire logic [pac_pkg::LEVEL_W-1:0] ref_upper,
  input wire logic [pac_pkg::LEVEL_W-1:0] ref_lower,
  output logic [pac_pkg::ADC_W-1:0] result,
  output logic finish
);

  logic [pac_pkg::ADC_W-1:0] code_ff, nxt_code;
  logic [pac_pkg::ADC_W-1:0] trial_ff, nxt_trial;
  logic [pac_pkg::ADC_W-1:0] result_ff, nxt_result;
  logic busy_ff, nxt_busy;
  logic finish_ff, nxt_finish;
  logic [pac_pkg::ADC_W-1:0] trial_code;
  logic [pac_pkg::PROD_W-1:0] lhs;
  logic [pac_pkg::PROD_W-1:0] rhs;
  logic [pac_pkg::LEVEL_W-1:0] span;
  logic keep;
  logic sat_hi;
  logic sat_lo;

  // ---------------------------------------------------------------
  // Compare scaled input against trial level
  // ---------------------------------------------------------------
  assign sat_hi = held >= ref_upper;
  assign sat_lo = held <= ref_lower;
  assign span = ref_upper - ref_lower;
  assign trial_code = code_ff | trial_ff;
  // Guarded against underflow; the low saturation overrides it anyway
  assign lhs = sat_lo ? '0 :
               {held - ref_lower, pac_pkg::CODE_ALL_ZEROS};
  assign rhs = pac_pkg::PROD_W'(span) * pac_pkg::PROD_W'(trial_code);
  assign keep = lhs >= rhs;

  always_comb begin
    nxt_code = code_ff;
    nxt_trial = trial_ff;
    nxt_busy = busy_ff;
    nxt_result = result_ff;
    nxt_finish = 1'b0;
    if (start) begin
      nxt_code = '0;
      nxt_trial = pac_pkg::TRIAL_FIRST;
      nxt_busy = 1'b1;
    end else if (busy_ff && step) begin
      if (keep) begin
        nxt_code = trial_code;
      end
      nxt_trial = trial_ff >> 1;
      if (trial_ff[0]) begin
        nxt_busy = 1'b0;
        nxt_finish = 1'b1;
        if (sat_hi) begin
          nxt_result = pac_pkg::CODE_ALL_ONES;
        end else if (sat_lo) begin
          nxt_result = pac_pkg::CODE_ALL_ZEROS;
        end else begin
          nxt_result = keep ? trial_code : code_ff;
        end
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      code_ff <= '0;
      trial_ff <= '0;
      result_ff <= '0;
      busy_ff <= 1'b0;
      finish_ff <= 1'b0;
    end else begin
      code_ff <= nxt_code;
      trial_ff <= nxt_trial;
      result_ff <= nxt_result;
      busy_ff <= nxt_busy;
      finish_ff <= nxt_finish;
    end
  end

  assign result = result_ff;
  assign finish = finish_ff;

endmodule

// ==== rtl/pac_conv_port.sv ====
// Notes on behaviour
// - Read and convert strobes count only while chip select is low.
// - Convert strobe rising edge under chip select starts a conversion.
// - Input is held from the start edge through the whole conversion.
// - Outside conversions the block tracks the input.
// - Result goes to the latch first, then done flag falls.
// - Latch changes only the cycle before done falls and holds until the next.
// - Chip select and read low drive the latch onto the bus.
// - Read strobe falling edge returns done flag high within a bound, except in the transfer cycle, where done falls.
// - Code saturates at all ones and all zeros at the references.
// - External clock, when running, replaces internal one after delay.
`timescale 1ns/1ps
module pac_conv_port (
  input wire logic clk,
  input wire logic rst,
  input wire pac_pkg::pac_strobe_s strobe,
  input wire logic external_clock_in,
  input wire logic [pac_pkg::LEVEL_W-1:0] analog_input,
  input wire logic [pac_pkg::LEVEL_W-1:0] ref_upper,
  input wire logic [pac_pkg::LEVEL_W-1:0] ref_lower,
  output pac_pkg::pac_bus_s result_bus,
  output logic done_n,
  output logic sampling
);

  pac_pkg::pac_state_e state_ff, nxt_state;
  logic wr_prev_ff, rd_prev_ff;
  logic [pac_pkg::LEVEL_W-1:0] hold_ff, nxt_hold;
  logic [pac_pkg::ADC_W-1:0] latch_ff, nxt_latch;
  logic done_n_ff, nxt_done_n;
  logic ext_prev_ff;
  logic ext_on_ff, nxt_ext_on;
  logic [pac_pkg::CNT_W-1:0] act_cnt_ff, nxt_act_cnt;
  logic [pac_pkg::CNT_W-1:0] idle_cnt_ff, nxt_idle_cnt;
  logic [7:0] div_ff, nxt_div;
  logic start;
  logic rd_fall;
  logic ext_edge;
  logic int_tick;
  logic step_tick;
  logic sar_start;
  logic sar_finish;
  logic [pac_pkg::ADC_W-1:0] sar_result;

  // ---------------------------------------------------------------
  // Strobe edges
  // ---------------------------------------------------------------
  assign start = !strobe.cs_n && strobe.wr_n && !wr_prev_ff;
  assign rd_fall = !strobe.cs_n && !strobe.rd_n && rd_prev_ff;
  assign sar_start = start && (state_ff == pac_pkg::st_track);

  // ---------------------------------------------------------------
  // Step clock selection
  // ---------------------------------------------------------------
  assign ext_edge = external_clock_in && !ext_prev_ff;
  assign int_tick = div_ff == pac_pkg::INT_STEP_LAST;
  // Internal steps stop once the external clock has taken over
  assign step_tick = ext_on_ff ? ext_edge : int_tick;

  always_comb begin
    nxt_div = int_tick ? '0 : div_ff + 8'h01;
    nxt_act_cnt = act_cnt_ff;
    nxt_ext_on = ext_on_ff;
    nxt_idle_cnt = ext_edge ? '0 : idle_cnt_ff;
    if (!ext_edge && idle_cnt_ff != pac_pkg::EXT_IDLE_LAST) begin
      nxt_idle_cnt = idle_cnt_ff + 11'h001;
    end
    // A stalled or tied-high input falls back to the internal clock
    if (!ext_edge && idle_cnt_ff == pac_pkg::EXT_IDLE_LAST) begin
      nxt_act_cnt = '0;
      nxt_ext_on = 1'b0;
    end else if (act_cnt_ff == pac_pkg::EXT_SWITCH_LAST) begin
      nxt_ext_on = 1'b1;
    end else if (ext_edge || act_cnt_ff != '0) begin
      nxt_act_cnt = act_cnt_ff + 11'h001;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_ff <= '0;
      ext_prev_ff <= 1'b1;
      ext_on_ff <= 1'b0;
      act_cnt_ff <= '0;
      idle_cnt_ff <= pac_pkg::EXT_IDLE_LAST;
    end else begin
      div_ff <= nxt_div;
      ext_prev_ff <= external_clock_in;
      ext_on_ff <= nxt_ext_on;
      act_cnt_ff <= nxt_act_cnt;
      idle_cnt_ff <= nxt_idle_cnt;
    end
  end

  // ---------------------------------------------------------------
  // Conversion sequence
  // ---------------------------------------------------------------
  pac_sar_core u_sar (
    .clk(clk),
    .rst(rst),
    .start(sar_start),
    .step(step_tick),
    .held(hold_ff),
    .ref_upper(ref_upper),
    .ref_lower(ref_lower),
    .result(sar_result),
    .finish(sar_finish)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_hold = hold_ff;
    nxt_latch = latch_ff;
    nxt_done_n = done_n_ff;
    if (rd_fall) begin
      nxt_done_n = 1'b1;
    end
    case (state_ff)
      pac_pkg::st_track: begin
        nxt_hold = analog_input;
        if (start) begin
          nxt_state = pac_pkg::st_convert;
        end
      end
      pac_pkg::st_convert: begin
        // Convert strobes during conversion are ignored; the hold stays frozen
        if (sar_finish) begin
          nxt_latch = sar_result;
          nxt_state = pac_pkg::st_transfer;
        end
      end
      pac_pkg::st_transfer: begin
        nxt_done_n = 1'b0;
        nxt_state = pac_pkg::st_track;
      end
      default: begin
        nxt_state = pac_pkg::st_track;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= pac_pkg::st_track;
      wr_prev_ff <= 1'b1;
      rd_prev_ff <= 1'b1;
      hold_ff <= '0;
      latch_ff <= '0;
      done_n_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      wr_prev_ff <= strobe.wr_n;
      rd_prev_ff <= strobe.rd_n;
      hold_ff <= nxt_hold;
      latch_ff <= nxt_latch;
      done_n_ff <= nxt_done_n;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign result_bus.data = latch_ff;
  assign result_bus.oe = !strobe.cs_n && !strobe.rd_n;
  assign done_n = done_n_ff;
  assign sampling = state_ff == pac_pkg::st_track;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  localparam int DONE_WAIT = pac_pkg::DONE_CLR_CYC;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  a_start_needs_cs: assert property (
    (state_ff == pac_pkg::st_track && strobe.cs_n) |=> sampling)
    else $error("conversion started without chip select");
  a_start_convert: assert property (
    sar_start |=> state_ff == pac_pkg::st_convert && !sampling)
    else $error("start edge did not begin a conversion");
  a_hold_frozen: assert property (
    (state_ff == pac_pkg::st_convert) |=> $stable(hold_ff))
    else $error("held input changed during conversion");
  a_track_follow: assert property (
    (state_ff == pac_pkg::st_track) |=> hold_ff == $past(analog_input))
    else $error("input not tracked while idle");
  a_latch_first: assert property (
    $fell(done_n) |-> $past(sar_finish, 2) && $stable(result_bus.data))
    else $error("done fell before the latch was loaded");
  a_latch_value: assert property (
    $fell(done_n) |-> result_bus.data == $past(sar_result, 2))
    else $error("latch does not hold the new result");
  a_latch_hold: assert property (
    $changed(result_bus.data) |-> state_ff == pac_pkg::st_transfer)
    else $error("latch changed outside a transfer");
  a_read_clears: assert property (
    (rd_fall && state_ff != pac_pkg::st_transfer) |-> ##[1:DONE_WAIT] done_n)
    else $error("read did not clear the done flag");
  a_sat_upper: assert property (
    sar_finish && $past(hold_ff >= ref_upper) |->
      sar_result == pac_pkg::CODE_ALL_ONES)
    else $error("upper saturation code wrong");
  a_sat_lower: assert property (
    sar_finish && $past(hold_ff <= ref_lower && hold_ff < ref_upper) |->
      sar_result == pac_pkg::CODE_ALL_ZEROS)
    else $error("lower saturation code wrong");
  a_int_off: assert property (
    (ext_on_ff && !ext_edge) |-> !step_tick)
    else $error("internal clock still stepping");
  a_bus_release: assert property (
    (strobe.cs_n || strobe.rd_n) |-> !result_bus.oe)
    else $error("bus driven without a read");
  a_bus_drive: assert property (
    (!strobe.cs_n && !strobe.rd_n) |-> result_bus.oe ##1
      (result_bus.data == $past(latch_ff) || $past(nxt_latch != latch_ff)))
    else $error("bus not driven during a read");

  c_conversion: cover property (sar_start ##[1:1000] $fell(done_n));
  c_read_clear: cover property ($fell(done_n) ##[1:50] $rose(done_n));
  c_ext_clock: cover property ($rose(ext_on_ff));

endmodule

// ==== bench/pac_host_model.sv ====
`timescale 1ns/1ps
module pac_host_model (
  input wire logic clk,
  input wire logic done_n,
  input wire logic oe,
  output pac_pkg::pac_strobe_s strobe
);
  // ----------
  // Host strobes
  // ----------
  // 50 ns minimum strobe width at 4 ns
  localparam int PULSE = 13;

  initial begin
    strobe = 3'h7;
  end

  // Convert or read; clr is the edge count until done_n is seen high
  task automatic pulse(input bit use_cs, input bit is_rd, output int clr,
      output bit oe_seen);
    clr = -1;
    oe_seen = 1'b0;
    @(posedge clk);
    #1;
    strobe.cs_n = !use_cs;
    strobe.rd_n = !is_rd;
    strobe.wr_n = is_rd;
    for (int i = 0; i < PULSE; i++) begin
      @(posedge clk);
      if (oe === 1'b1) oe_seen = 1'b1;
      if (clr < 0 && done_n === 1'b1) clr = i;
    end
    #1;
    strobe.rd_n = 1'b1;
    strobe.wr_n = 1'b1;
    // Chip select held past the rising strobe edge
    @(posedge clk);
    #1;
    strobe.cs_n = 1'b1;
  endtask

  task automatic wait_done(output int cyc);
    cyc = 0;
    while (done_n !== 1'b0 && cyc < 4000) begin
      @(posedge clk);
      cyc++;
    end
    #1;
  endtask
endmodule

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic clk;
  logic rst;
  logic ext_on;
  logic ext_clk;
  logic [3:0] ext_div;
  logic [11:0] level_in;
  logic [11:0] hi;
  logic [11:0] lo;
  pac_pkg::pac_strobe_s strobe;
  pac_pkg::pac_bus_s bus;
  logic done_n;
  logic sampling;
  logic done_d;
  logic oe_d;
  logic [9:0] cur;
  logic [9:0] exp_q[$];
  logic [31:0] seed;
  int fails;
  int cmp_count;
  int cyc;
  int clr;
  bit oe_seen;
  logic [11:0] sat_tab[5];

  pac_conv_port dut_u (
    .clk(clk),
    .rst(rst),
    .strobe(strobe),
    .external_clock_in(ext_clk),
    .analog_input(level_in),
    .ref_upper(hi),
    .ref_lower(lo),
    .result_bus(bus),
    .done_n(done_n),
    .sampling(sampling)
  );

  pac_host_model host_u (
    .clk(clk),
    .done_n(done_n),
    .oe(bus.oe),
    .strobe(strobe)
  );

  always #2 clk = ~clk;

  // ----------
  // Helpers
  // ----------
  function logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Upper reference wins when refs are inverted
  function automatic logic [9:0] exp_code(input logic [11:0] a, h, l);
    logic [23:0] num;
    if (a >= h) return 10'h3ff;
    if (a <= l) return 10'h000;
    num = 24'(a - l) << 10;
    return 10'(num / 24'(h - l));
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize;
    $display("cmp_count=%0d fails=%0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // One conversion, a refused read, then two reads
  task automatic conv(input logic [11:0] a, input bit again, input int lmin,
      input int lmax);
    int n;
    int k;
    bit seen;
    level_in = a;
    exp_q.push_back(exp_code(a, hi, lo));
    host_u.pulse(1, 0, k, seen);
    @(posedge clk);
    #1;
    check(sampling, 0);
    // Input moves while held; the code must not follow it
    level_in = 12'(xs());
    if (again) host_u.pulse(1, 0, k, seen);
    host_u.wait_done(n);
    check(n >= lmin && n <= lmax, 1);
    check(sampling, 1);
    host_u.pulse(0, 1, k, seen);
    check(seen, 0);
    check(done_n, 0);
    for (int r = 0; r < 2; r++) begin
      host_u.pulse(1, 1, k, seen);
      check(seen, 1);
      if (r == 0) check(k >= 1 && k <= pac_pkg::DONE_CLR_CYC, 1);
    end
  endtask

  // ----------
  // Result monitor
  // ----------
  always @(posedge clk) begin
    done_d <= done_n;
    oe_d <= bus.oe;
    if (!rst && done_d === 1'b1 && done_n === 1'b0) begin
      if (exp_q.size() == 0) begin
        fails++;
        $display("[ERR] t=%0t got=%h exp=%h", $time, bus.data, 10'h000);
      end else begin
        cur = exp_q.pop_front();
        check(bus.data, cur);
      end
    end
    if (bus.oe === 1'b1 && oe_d !== 1'b1) check(bus.data, cur);
  end

  always @(posedge clk) begin
    ext_div <= ext_div + 4'h1;
    ext_clk <= #1 (ext_on ? ext_div[3] : 1'b1);
    cyc++;
    if (cyc == 40000) begin
      fails++;
      summarize;
    end
  end

  initial begin
    clk = 0;
    rst = 1;
    ext_on = 0;
    ext_clk = 1;
    ext_div = 4'h0;
    level_in = 12'h000;
    hi = 12'h800;
    lo = 12'h000;
    done_d = 1;
    oe_d = 0;
    cur = 10'h000;
    seed = 32'h0000_0061;
    sat_tab = '{12'h900, 12'hfff, 12'h100, 12'h050, 12'h500};
    repeat (12) @(posedge clk);
    #1;
    rst = 0;
    @(posedge clk);
    #1;
    for (int i = 0; i < 3; i++) conv(12'(xs()), 0, 1100, 1300);
    $display("test random codes done");
    hi = 12'h900;
    lo = 12'h100;
    foreach (sat_tab[i]) conv(sat_tab[i], 0, 1100, 1300);
    $display("test saturation done");
    host_u.pulse(0, 0, clr, oe_seen);
    repeat (4) @(posedge clk);
    #1;
    check(sampling, 1);
    conv(12'(xs()), 1, 1000, 1300);
    $display("test refused starts done");
    ext_on = 1;
    repeat (1100) @(posedge clk);
    #1;
    conv(12'(xs()), 0, 140, 260);
    ext_on = 0;
    repeat (1100) @(posedge clk);
    #1;
    conv(12'(xs()), 0, 1100, 1300);
    $display("test clock source done");
    check(exp_q.size(), 0);
    summarize;
  end
endmodule
